// file: ecr_regs.sv
// Encoder config and caption payload registers with their control effects
`timescale 1ns/1ns
`default_nettype none
`include "ecr_defines.svh"

// What this block does
// - Config bit swaps even and odd field identity
// - Config bit swaps red and blue chroma order
// - Two bits pick pixel alignment against line sync
// - Config bit picks line reset pulse edge
// - Config bit gates subcarrier phase input pin
// - Two bits enable captions on lines 21, 284
// - Config bit picks 9 or 15 blanked lines
// - Config bit drops setup pedestal, boosts gain
// - Config bit scales for full amplitude video
// - Config bit places reset at digital/analog edge
// - Config bit picks abrupt or smooth blanking
// - Config bit aligns reset to blanking or active
// - Config bit picks sync pins or embedded codes
// - Config bit picks square or standard pixel rate
// - Config bit picks timing master or slave
// - Low payload half feeds first enabled line
// - High payload half used only when both enabled
// - Function address 00 payload, 03 config
// - Bytes arrive MSB first plus ignored clock
module ecr_regs
    import ecr_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // Serial control bus
    input  wire logic        sclk,
    input  wire logic        sdata,
    // Video timing from the datapath
    input  wire logic        field_in,
    input  wire logic        chroma_cr_in,
    input  wire logic        hsync_in,
    input  wire logic        embedded_hreset_in,
    input  wire logic        phase_err_in,
    // Caption slot strobes
    input  wire logic        line_first_start,
    input  wire logic        line_second_start,
    input  wire logic        line_done,
    // Decoded settings for timing logic
    output ecr_ctrl_t        ctrl,
    // Processed video controls
    output logic             field_out,
    output logic             chroma_cr_out,
    output logic             hreset_pulse,
    output logic             subcarrier_phase_input,
    // Caption service outputs
    output logic [15:0]      caption_word,
    output logic             caption_active,
    output logic             caption_on_second,
    // Levels and blanking
    output logic [4:0]       vblank_lines,
    output logic             setup_pedestal_on,
    output logic             gain_boost_on,
    output logic             amplitude_scale_on
);

    // One completed bus write
    ecr_wr_t      wr;
    // Stored register words
    logic [31:0]  config_reg;
    logic [31:0]  caption_reg;
    // Line reset edge detection
    logic         hsync_q;
    logic         sync_rise;
    logic         sync_fall;
    logic         sync_edge;
    // Caption line enables
    logic         cap_first_en;
    logic         cap_second_en;

    ////////////////////////////////////////////////////////////////////////////
    // Serial front end
    // Strobe comes only after a whole fourth byte
    ecr_serial_rx u_rx
    (
        .mclk  (mclk),
        .rst_n (rst_n),
        .sclk  (sclk),
        .sdata (sdata),
        .wr    (wr)
    );

    // Field unpacking used only for the ctrl output; the datapath reads config_reg bits itself
    function automatic ecr_ctrl_t ecr_decode(input logic [31:0] c);
        ecr_ctrl_t d;
        d.field_swap                 = c[`ECR_B_FIELD_SWAP];
        d.chroma_order_swap          = c[`ECR_B_CHROMA_SWAP];
        d.pixel_align_sel            = {c[`ECR_B_ALIGN_HI], c[`ECR_B_ALIGN_LO]};
        d.hreset_rising              = c[`ECR_B_HRESET_RISE];
        d.phase_enable               = c[`ECR_B_PHASE_EN];
        d.frame_sync                 = c[`ECR_B_FRAME_SYNC];
        d.caption_second_line_enable = c[`ECR_B_CAP_SECOND];
        d.caption_first_line_enable  = c[`ECR_B_CAP_FIRST];
        d.wide_blank                 = c[`ECR_B_WIDE_BLANK];
        d.japan_levels               = c[`ECR_B_JAPAN];
        d.full_amplitude             = c[`ECR_B_FULL_AMP];
        d.line_reset_position_sel    = c[`ECR_B_RESET_POS];
        d.smooth_blanking_sel        = c[`ECR_B_SMOOTH_BLANK];
        d.line_reset_align_sel       = c[`ECR_B_RESET_ALIGN];
        d.embedded_timing            = c[`ECR_B_EMBEDDED];
        d.pixel_rate_sel             = c[`ECR_B_PIXEL_RATE];
        d.slave_role                 = c[`ECR_B_SLAVE];
        d.composite_blank            = c[`ECR_B_COMP_BLANK];
        return d;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Register file; a whole word lands in one cycle, never a partial one
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            config_reg  <= `ECR_CONFIG_RESET;
            caption_reg <= `ECR_CAPTION_RESET;
        end
        else if (wr.valid)
        begin
            // Reserved bits are stored as sent; host keeps them at one
            if (wr.func == `ECR_FUNC_CONFIG)
            begin
                config_reg <= wr.data;
            end
            // Codes differ, so one strobe writes one word
            if (wr.func == `ECR_FUNC_CAPTION)
            begin
                caption_reg <= wr.data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Decoded controls out, registered so they move with the stored word
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            // Reset word has every decoded field clear
            ctrl <= '0;
        end
        else
        begin
            ctrl <= ecr_decode(config_reg);
            // Alignment select inert in embedded-code slave mode
            if (config_reg[`ECR_B_SLAVE] && config_reg[`ECR_B_EMBEDDED])
            begin
                ctrl.pixel_align_sel <= 2'b00;
            end
            else
            begin
                ctrl.pixel_align_sel <= {config_reg[`ECR_B_ALIGN_HI],
                                         config_reg[`ECR_B_ALIGN_LO]};
            end
        end
    end
    // those selects travel to timing logic via ctrl

    ////////////////////////////////////////////////////////////////////////////
    // Field and chroma order swaps
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            field_out     <= 1'b0;
            chroma_cr_out <= 1'b0;
        end
        else
        begin
            // One cycle late, like every other output
            field_out     <= field_in ^ config_reg[`ECR_B_FIELD_SWAP];
            // Swapping mid-line may leave a stray sample at line end
            chroma_cr_out <= chroma_cr_in ^ config_reg[`ECR_B_CHROMA_SWAP];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Line reset: chosen sync edge, or the embedded code strobe
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hsync_q <= 1'b0;
        end
        else
        begin
            hsync_q <= hsync_in;
        end
    end

    // Both edges are formed, then the polarity bit picks one
    assign sync_rise = hsync_in & ~hsync_q;
    assign sync_fall = ~hsync_in & hsync_q;
    assign sync_edge = config_reg[`ECR_B_HRESET_RISE] ? sync_rise : sync_fall;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hreset_pulse <= 1'b0;
        end
        else if (config_reg[`ECR_B_EMBEDDED])
        begin
            // Pin edges are ignored while embedded codes rule
            hreset_pulse <= embedded_hreset_in;
        end
        else
        begin
            hreset_pulse <= sync_edge;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Phase pin gate: held low while the pin is not in use
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            subcarrier_phase_input <= 1'b0;
        end
        else
        begin
            // A floating pin must not steer the oscillator
            subcarrier_phase_input <= phase_err_in & config_reg[`ECR_B_PHASE_EN];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Level and blanking settings
    // Registered so a write cannot glitch them
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            vblank_lines       <= `ECR_VBLANK_NARROW;
            setup_pedestal_on  <= 1'b1;
            gain_boost_on      <= 1'b0;
            amplitude_scale_on <= 1'b0;
        end
        else
        begin
            vblank_lines       <= config_reg[`ECR_B_WIDE_BLANK] ? `ECR_VBLANK_WIDE
                                                               : `ECR_VBLANK_NARROW;
            // Japanese levels trade the pedestal for extra gain
            setup_pedestal_on  <= ~config_reg[`ECR_B_JAPAN];
            gain_boost_on      <= config_reg[`ECR_B_JAPAN];
            amplitude_scale_on <= config_reg[`ECR_B_FULL_AMP];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Caption line service
    // Enables read straight from the stored word
    assign cap_first_en  = config_reg[`ECR_B_CAP_FIRST];
    assign cap_second_en = config_reg[`ECR_B_CAP_SECOND];

    // Word is sampled at line start and frozen until line_done, so a
    // payload write during the line only shows on the next line
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            caption_word      <= 16'h0000;
            caption_active    <= 1'b0;
            caption_on_second <= 1'b0;
        end
        else if (caption_active)
        begin
            // Start strobes are refused until the line ends
            if (line_done)
            begin
                caption_active <= 1'b0;
            end
        end
        // First line wins when both strobes coincide
        else if (line_first_start && cap_first_en)
        begin
            caption_word      <= caption_reg[`ECR_CAP_LO_MSB:0];
            caption_active    <= 1'b1;
            caption_on_second <= 1'b0;
        end
        else if (line_second_start && cap_second_en)
        begin
            // High half only when both lines are enabled
            if (cap_first_en)
            begin
                caption_word  <= caption_reg[`ECR_CAP_HI_MSB:`ECR_CAP_HI_LSB];
            end
            else
            begin
                caption_word  <= caption_reg[`ECR_CAP_LO_MSB:0];
            end
            caption_active    <= 1'b1;
            caption_on_second <= 1'b1;
        end
    end

endmodule
`default_nettype wire

// file: ecr_defines.svh
// Offsets, field positions, reset values and counts for the encoder config registers
`ifndef ECR_DEFINES_SVH
`define ECR_DEFINES_SVH

// Serial bus addressing
`define ECR_DEV_ADDR          8'hb4
`define ECR_FUNC_CAPTION      8'h00
`define ECR_FUNC_CONFIG       8'h03
`define ECR_BITS_PER_BYTE     4'h8
`define ECR_DATA_BYTES        2'h3

// Main config register field positions
`define ECR_B_FIELD_SWAP      11
`define ECR_B_CHROMA_SWAP     12
`define ECR_B_ALIGN_LO        13
`define ECR_B_ALIGN_HI        14
`define ECR_B_HRESET_RISE     15
`define ECR_B_PHASE_EN        16
`define ECR_B_FRAME_SYNC      17
`define ECR_B_CAP_SECOND      18
`define ECR_B_CAP_FIRST       19
`define ECR_B_WIDE_BLANK      20
`define ECR_B_JAPAN           21
`define ECR_B_FULL_AMP        22
`define ECR_B_RESET_POS       23
`define ECR_B_SMOOTH_BLANK    24
`define ECR_B_RESET_ALIGN     25
`define ECR_B_EMBEDDED        26
`define ECR_B_PIXEL_RATE      27
`define ECR_B_SLAVE           28
`define ECR_B_COMP_BLANK      29

// Caption payload layout
`define ECR_CAP_LO_MSB        15
`define ECR_CAP_HI_LSB        16
`define ECR_CAP_HI_MSB        31

// Reset values: reserved top bits set, everything else off
`define ECR_CONFIG_RESET      32'hc000_0000
`define ECR_CAPTION_RESET     32'h0000_0000

// Vertical blanking line counts
`define ECR_VBLANK_NARROW     5'h09
`define ECR_VBLANK_WIDE       5'h0f

`endif

// file: ecr_pkg.sv
// Types shared by the encoder config register bank
package ecr_pkg;

    // Receiver states, Gray along idle-dev-func-data
    typedef enum logic [2:0] {
        ECR_IDLE   = 3'b000,
        ECR_DEV    = 3'b001,
        ECR_FUNC   = 3'b011,
        ECR_DATA   = 3'b010,
        ECR_IGNORE = 3'b110
    } ecr_rx_state_t;

    // One completed register write from the serial bus
    typedef struct packed {
        logic        valid;
        logic [7:0]  func;
        logic [31:0] data;
    } ecr_wr_t;

    // Decoded upper config fields
    typedef struct packed {
        logic       field_swap;
        logic       chroma_order_swap;
        logic [1:0] pixel_align_sel;
        logic       hreset_rising;
        logic       phase_enable;
        logic       frame_sync;
        logic       caption_second_line_enable;
        logic       caption_first_line_enable;
        logic       wide_blank;
        logic       japan_levels;
        logic       full_amplitude;
        logic       line_reset_position_sel;
        logic       smooth_blanking_sel;
        logic       line_reset_align_sel;
        logic       embedded_timing;
        logic       pixel_rate_sel;
        logic       slave_role;
        logic       composite_blank;
    } ecr_ctrl_t;

endpackage

// file: ecr_serial_rx.sv
// Two-wire serial receiver: start/stop, device and function address, four data bytes
`timescale 1ns/1ns
`default_nettype none
`include "ecr_defines.svh"

module ecr_serial_rx
    import ecr_pkg::*;
(
    input  wire logic     mclk,
    input  wire logic     rst_n,
    input  wire logic     sclk,
    input  wire logic     sdata,
    output ecr_wr_t       wr
);

    logic          sclk_q;
    logic          sdata_q;
    logic          sclk_rise;
    logic          start_seen;
    logic          stop_seen;
    ecr_rx_state_t state_reg;
    logic [3:0]    bit_cnt_reg;
    logic [1:0]    byte_cnt_reg;
    logic [7:0]    shift_reg;
    logic [7:0]    func_reg;
    logic [31:0]   data_reg;
    logic          last_clock;

    ////////////////////////////////////////////////////////////////////////////
    // Edge history; pins are synchronous to mclk
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sclk_q  <= 1'b1;
            sdata_q <= 1'b1;
        end
        else
        begin
            sclk_q  <= sclk;
            sdata_q <= sdata;
        end
    end

    assign sclk_rise  = sclk & ~sclk_q;
    assign start_seen = sclk & sclk_q & sdata_q & ~sdata;
    assign stop_seen  = sclk & sclk_q & ~sdata_q & sdata;
    // Ninth clock of each group carries no data
    assign last_clock = sclk_rise && (bit_cnt_reg == `ECR_BITS_PER_BYTE);

    ////////////////////////////////////////////////////////////////////////////
    // Byte shifter, MSB first, bit counter 0..8
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            shift_reg   <= 8'h00;
            bit_cnt_reg <= 4'h0;
        end
        else if (start_seen || stop_seen)
        begin
            bit_cnt_reg <= 4'h0;
        end
        else if (sclk_rise)
        begin
            if (bit_cnt_reg == `ECR_BITS_PER_BYTE)
                bit_cnt_reg <= 4'h0;
            else
            begin
                shift_reg   <= {shift_reg[6:0], sdata};
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Framing state machine
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg    <= ECR_IDLE;
            byte_cnt_reg <= 2'h0;
            func_reg     <= 8'h00;
            data_reg     <= 32'h0000_0000;
        end
        else if (start_seen)
        begin
            state_reg    <= ECR_DEV;
            byte_cnt_reg <= 2'h0;
        end
        else if (stop_seen)
            state_reg <= ECR_IDLE;
        else if (last_clock)
        begin
            case (state_reg)
                ECR_DEV:
                    state_reg <= (shift_reg == `ECR_DEV_ADDR) ? ECR_FUNC : ECR_IGNORE;
                ECR_FUNC:
                begin
                    func_reg  <= shift_reg;
                    state_reg <= (shift_reg == `ECR_FUNC_CAPTION ||
                                  shift_reg == `ECR_FUNC_CONFIG) ? ECR_DATA : ECR_IGNORE;
                end
                ECR_DATA:
                begin
                    data_reg     <= {data_reg[23:0], shift_reg};
                    byte_cnt_reg <= byte_cnt_reg + 2'h1;
                    // Extra bytes after the fourth are dropped
                    if (byte_cnt_reg == `ECR_DATA_BYTES)
                        state_reg <= ECR_IGNORE;
                end
                ECR_IGNORE: state_reg <= ECR_IGNORE;
                default:    state_reg <= ECR_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write strobe only once the fourth byte is whole
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            wr <= '0;
        else
        begin
            wr.valid <= last_clock && (state_reg == ECR_DATA) &&
                        (byte_cnt_reg == `ECR_DATA_BYTES);
            wr.func  <= func_reg;
            wr.data  <= {data_reg[23:0], shift_reg};
        end
    end

endmodule
`default_nettype wire

// file: ecr_host_model.sv
// Host master model driving the two-wire serial control bus
`timescale 1ns/1ns
`default_nettype none
module ecr_host_model
(
    input  wire logic mclk,
    output var logic  sclk = 1'b1,
    output var logic  sdata = 1'b1
);
    ////////////////////////////////////////////////////////////
    // Set both lines just after a falling edge, hold hold+1 cycles
    task automatic step(input logic c, input logic d, input int hold);
        @(negedge mclk);
        sclk = c;
        sdata = d;
        repeat (hold) @(negedge mclk);
    endtask

    // Start, device, function, n bytes MSB first, stop; n below 4 aborts
    // Data only moves while the clock is low, so no false start or stop
    task automatic send(input logic [7:0] fn, input logic [7:0] dev,
                        input logic [31:0] d, input int n, input int hold);
        logic [47:0] s;
        logic        b;
        s = {dev, fn, ((fn == 8'h03) ? (d | 32'hc000_0000) : d)};
        step(1'b1, 1'b1, hold);
        step(1'b1, 1'b0, hold);
        for (int k = 0; k < 9 * (n + 2); k++)
        begin
            b = (k % 9 == 8) || s[47 - k + k / 9];
            step(1'b0, b, hold);
            step(1'b1, b, hold);
        end
        step(1'b0, 1'b0, hold);
        step(1'b1, 1'b0, hold);
        step(1'b1, 1'b1, hold);
    endtask
endmodule
`default_nettype wire

// file: ecr_regs_props.sv
// Concurrent checks on the encoder config bank ports
`timescale 1ns/1ns
`default_nettype none
module ecr_regs_props
    import ecr_pkg::*;
(
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire logic        field_in,
    input wire logic        chroma_cr_in,
    input wire logic        hsync_in,
    input wire logic        embedded_hreset_in,
    input wire logic        phase_err_in,
    input wire logic        line_first_start,
    input wire logic        line_done,
    input wire ecr_ctrl_t   ctrl,
    input wire logic        field_out,
    input wire logic        chroma_cr_out,
    input wire logic        hreset_pulse,
    input wire logic        subcarrier_phase_input,
    input wire logic        caption_active,
    input wire logic        caption_on_second,
    input wire logic [15:0] caption_word
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////////////////////////
    // History depth after reset, so $past never sees reset values
    logic [2:0] up_q;
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            up_q <= 3'h0;
        else
            up_q <= {up_q[1:0], 1'b1};
    end

    a_field_swap_map: assert property (
        up_q[2] && $stable(ctrl) |-> field_out == ($past(field_in) ^ ctrl.field_swap))
        else $error("field swap wrong");
    a_chroma_swap_map: assert property (
        up_q[2] && $stable(ctrl) |->
        chroma_cr_out == ($past(chroma_cr_in) ^ ctrl.chroma_order_swap))
        else $error("chroma swap wrong");
    a_phase_pin_gate: assert property (
        up_q[2] && $stable(ctrl) |->
        subcarrier_phase_input == ($past(phase_err_in) && ctrl.phase_enable))
        else $error("phase gate wrong");
    a_hsync_edge_pick: assert property (
        up_q[2] && $stable(ctrl) && !ctrl.embedded_timing |-> hreset_pulse ==
        ($past(hsync_in) != $past(hsync_in, 2) && $past(hsync_in) == ctrl.hreset_rising))
        else $error("hsync edge pulse wrong");
    a_embedded_reset: assert property (
        up_q[2] && $stable(ctrl) && ctrl.embedded_timing |->
        hreset_pulse == $past(embedded_hreset_in))
        else $error("embedded reset pulse wrong");
    a_caption_first: assert property (
        up_q[2] && !caption_active && line_first_start && ctrl.caption_first_line_enable
        ##1 $stable(ctrl) |-> caption_active && !caption_on_second)
        else $error("first caption line not taken");
    a_caption_held: assert property (
        caption_active && !line_done |=> caption_active && $stable(caption_word)
        && $stable(caption_on_second))
        else $error("caption changed mid line");
    a_caption_ends: assert property (
        caption_active && line_done |=> !caption_active)
        else $error("caption line did not end");
endmodule
bind ecr_regs ecr_regs_props props (
    .mclk, .rst_n, .field_in, .chroma_cr_in, .hsync_in, .embedded_hreset_in, .phase_err_in,
    .line_first_start, .line_done, .ctrl, .field_out, .chroma_cr_out, .hreset_pulse,
    .subcarrier_phase_input, .caption_active, .caption_on_second, .caption_word
);
`default_nettype wire

// file: encoder_config_caption_regs_tb.sv
// Self-checking bench for the encoder config and caption register bank
`timescale 1ns/1ns
`default_nettype none
`include "ecr_defines.svh"
module encoder_config_caption_regs_tb
    import ecr_pkg::*;
;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic        sclk, sdata;
    logic        field_in = 1'b0, chroma_cr_in = 1'b0, hsync_in = 1'b0, phase_err_in = 1'b0;
    logic        embedded_hreset_in = 1'b0;
    logic        line_first_start = 1'b0, line_second_start = 1'b0, line_done = 1'b0;
    ecr_ctrl_t   ctrl;
    logic        field_out, chroma_cr_out, hreset_pulse, subcarrier_phase_input;
    logic        caption_active, caption_on_second, setup_pedestal_on, gain_boost_on;
    logic        amplitude_scale_on;
    logic [15:0] caption_word;
    logic [4:0]  vblank_lines;
    integer      seed = 32'h3937;
    int          err_total = 0;
    int          cmp_count = 0;
    int          cyc = 0;
    logic [31:0] cfg;
    logic [31:0] cc;

    ecr_host_model host (.mclk, .sclk, .sdata);
    ecr_regs dut (
        .mclk, .rst_n, .sclk, .sdata, .field_in, .chroma_cr_in, .hsync_in,
        .embedded_hreset_in, .phase_err_in, .line_first_start, .line_second_start, .line_done,
        .ctrl, .field_out, .chroma_cr_out, .hreset_pulse, .subcarrier_phase_input,
        .caption_word, .caption_active, .caption_on_second, .vblank_lines,
        .setup_pedestal_on, .gain_boost_on, .amplitude_scale_on
    );

    ////////////////////////////////////////////////////////////
    // Clock, plus a cycle limit so a hang still reaches the report
    always #5 mclk = ~mclk;
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 90000)
        begin
            err_total++;
            results();
        end
    end

    // Random sync-side pins; the embedded strobe never holds two cycles
    always @(negedge mclk)
    begin
        {field_in, chroma_cr_in, hsync_in, phase_err_in} <= 4'($random(seed));
        embedded_hreset_in <= 1'($random(seed)) & ~embedded_hreset_in;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic results();
        $display("Compared %0d, mismatched %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Fields sit in bit order; alignment is dropped in slave embedded mode
    function automatic logic [31:0] exp_ctrl(input logic [31:0] d);
        ecr_ctrl_t c;
        c = {<<{d[29:11]}};
        c.pixel_align_sel = (d[28] && d[26]) ? 2'b00 : {d[14], d[13]};
        return 32'(c);
    endfunction

    // Everything decoded must follow the last complete write
    task automatic cfg_check();
        logic [2:0] lv;
        lv = {setup_pedestal_on, gain_boost_on, amplitude_scale_on};
        chk("ctrl", exp_ctrl(cfg), 32'(ctrl));
        chk("vblank", cfg[20] ? 32'h0f : 32'h09, 32'(vblank_lines));
        chk("levels", 32'({~cfg[21], cfg[21], cfg[22]}), 32'(lv));
    endtask

    // Random bus speed, so both prompt and slow hosts are seen
    task automatic cfg_write(input logic [31:0] d);
        host.send(`ECR_FUNC_CONFIG, `ECR_DEV_ADDR, d, 4, 1 + {$random(seed)} % 4);
        cfg = d;
        cfg_check();
    endtask

    // One start pulse; en is first line enable then second line enable
    task automatic cap_start(input logic sec, input logic [1:0] en, input logic [31:0] p);
        logic on;
        on = sec ? en[0] : en[1];
        @(negedge mclk);
        line_first_start = ~sec;
        line_second_start = sec;
        @(negedge mclk);
        line_first_start = 1'b0;
        line_second_start = 1'b0;
        chk("cap_active", 32'(on), 32'(caption_active));
        if (on)
        begin
            chk("cap_word", 32'((sec && en == 2'b11) ? p[31:16] : p[15:0]), 32'(caption_word));
            chk("cap_second", 32'(sec), 32'(caption_on_second));
        end
    endtask

    task automatic cap_end();
        @(negedge mclk);
        line_done = 1'b1;
        @(negedge mclk);
        line_done = 1'b0;
        chk("cap_idle", 32'h0, 32'(caption_active));
    endtask

    // Reset, bit walk, refused writes, caption slots, mid-line update, reset again
    initial
    begin
        repeat (6) @(negedge mclk);
        rst_n = 1'b1;
        cfg = `ECR_CONFIG_RESET;
        cfg_check();
        repeat (2) @(negedge mclk);
        for (int i = 11; i < 30; i++)
            cfg_write(32'h1 << i);
        cfg_write(32'h0000_6000);
        cfg_write(32'h1400_6000);
        repeat (5) cfg_write($random(seed));
        host.send(`ECR_FUNC_CONFIG, `ECR_DEV_ADDR, ~cfg, 3, 1);
        cfg_check();
        host.send(`ECR_FUNC_CONFIG, 8'hb6, ~cfg, 4, 1);
        cfg_check();
        host.send(8'h01, `ECR_DEV_ADDR, ~cfg, 4, 1);
        cfg_check();
        for (int e = 0; e < 4; e++)
        begin
            cfg_write(32'(e) << 18);
            cc = $random(seed);
            host.send(`ECR_FUNC_CAPTION, `ECR_DEV_ADDR, cc, 4, 2);
            cap_start(1'b0, 2'(e), cc);
            if (e > 1)
                cap_end();
            cap_start(1'b1, 2'(e), cc);
            if (e % 2)
                cap_end();
        end
        cap_start(1'b0, 2'b11, cc);
        host.send(`ECR_FUNC_CAPTION, `ECR_DEV_ADDR, ~cc, 4, 1);
        chk("cap_hold", 32'(cc[15:0]), 32'(caption_word));
        cc = ~cc;
        cap_end();
        cap_start(1'b1, 2'b11, cc);
        cap_end();
        rst_n = 1'b0;
        @(negedge mclk);
        cfg = `ECR_CONFIG_RESET;
        cfg_check();
        chk("cap_reset", 32'h0, 32'(caption_active));
        rst_n = 1'b1;
        repeat (2) @(negedge mclk);
        cfg_write(32'h0810_0000);
        results();
    end
endmodule
`default_nettype wire
